// File: shared/evtmr_pkg.sv
/*
 * Constants for the event triggered countdown timer block: register
 * indices, config field positions, reset values and widths.
 * Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
 */
package evtmr_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W = 20;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PRESC_SEL_W = 3;
    localparam int unsigned PRESC_CNT_W = 8;
    localparam int unsigned NUM_TIMERS = 2;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_T0_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] IDX_T1_STATUS = 8'h09;
    localparam logic [ADDR_W-1:0] IDX_T0_PRESET = 8'h0B;
    localparam logic [ADDR_W-1:0] IDX_T1_PRESET = 8'h0C;
    localparam logic [ADDR_W-1:0] IDX_T0_CONFIG = 8'h0E;
    localparam logic [ADDR_W-1:0] IDX_T1_CONFIG = 8'h0F;
    localparam int unsigned IDX_LSB = 2;

    // ------------------------------------------------------------------
    // Config register fields
    // ------------------------------------------------------------------
    localparam int unsigned CFG_HALT_RX_BEGIN = 20;
    localparam int unsigned CFG_HALT_TX_BEGIN = 19;
    localparam int unsigned CFG_HALT_EXT_SEEN = 18;
    localparam int unsigned CFG_HALT_EXT_LOST = 17;
    localparam int unsigned CFG_HALT_OWN_ON = 16;
    localparam int unsigned CFG_HALT_OWN_OFF = 15;
    localparam int unsigned CFG_GO_RX_BEGIN = 14;
    localparam int unsigned CFG_GO_RX_END = 13;
    localparam int unsigned CFG_GO_TX_BEGIN = 12;
    localparam int unsigned CFG_GO_TX_END = 11;
    localparam int unsigned CFG_GO_EXT_SEEN = 10;
    localparam int unsigned CFG_GO_EXT_LOST = 9;
    localparam int unsigned CFG_GO_OWN_ON = 8;
    localparam int unsigned CFG_GO_OWN_OFF = 7;
    localparam int unsigned CFG_IMM_START = 6;
    localparam int unsigned CFG_RATE_MSB = 5;
    localparam int unsigned CFG_RATE_LSB = 3;
    localparam int unsigned CFG_CLK_MODE = 2;
    localparam int unsigned CFG_RELOAD = 1;
    localparam int unsigned CFG_ON = 0;
    localparam int unsigned CFG_MSB = 20;
    localparam int unsigned STAT_RUN = 20;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CFG_MSB:0] CFG_RST = 21'h000000;
    localparam logic [CNT_W-1:0] PRESET_RST = 20'h00000;
    localparam logic [CNT_W-1:0] COUNT_RST = 20'h00000;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
    localparam logic [PRESC_CNT_W-1:0] PRESC_RST = 8'h00;

endpackage : evtmr_pkg

// File: src/evtmr_prescaler.sv
/*
 * Divides the contactless interface clock strobe by 2^(rate+1).
 * Assumes contactless_interface_clock_tick_i is a one-cycle strobe in the clk_i domain.
 */
`timescale 1ns/10ps
`default_nettype none

module evtmr_prescaler #(
    parameter int unsigned SEL_W = evtmr_pkg::PRESC_SEL_W,
    parameter int unsigned DIV_W = evtmr_pkg::PRESC_CNT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic [SEL_W-1:0] rate_i,
    input wire logic contactless_interface_clock_tick_i,
    // Output strobe
    output logic tick_o
);

    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] nxt_div;
    logic [DIV_W-1:0] mask;

    // ------------------------------------------------------------------
    // Free running divider
    // ------------------------------------------------------------------
    assign nxt_div = div_ff + {{(DIV_W-1){1'b0}}, 1'b1};

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_ff <= evtmr_pkg::PRESC_RST;
        end else if (contactless_interface_clock_tick_i) begin
            div_ff <= nxt_div;
        end
    end

    // rate halving select
    // Widened sum: the top code must shift by 2^SEL_W without wrapping
    assign mask = DIV_W'((DIV_W'(1) << ({1'b0, rate_i} + (SEL_W+1)'(1))) - DIV_W'(1));
    assign tick_o = contactless_interface_clock_tick_i & ((div_ff & mask) == mask);

endmodule // evtmr_prescaler

`default_nettype wire

// File: src/evtmr_counter.sv
/*
 * One 20-bit countdown timer core with start, stop, expiry and reload.
 * Assumes start and stop are one-cycle strobes already gated by selects.
 */
`timescale 1ns/10ps
`default_nettype none

module evtmr_counter #(
    parameter int unsigned CNT_W = evtmr_pkg::CNT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic on_i,
    input wire logic clk_mode_i,
    input wire logic reload_i,
    input wire logic contactless_interface_clock_tick_i,
    input wire logic presc_tick_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [CNT_W-1:0] preset_i,
    // Status
    output logic [CNT_W-1:0] count_o,
    output logic running_o
);

    logic [CNT_W-1:0] count_ff;
    logic running_ff;
    logic step;
    logic expire;

    assign step = clk_mode_i ? presc_tick_i : contactless_interface_clock_tick_i;
    assign expire = running_ff & step & (count_ff == '0);

    // ------------------------------------------------------------------
    // Running flag; stop wins over a start in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            running_ff <= 1'b0;
        end else if (!on_i) begin
            running_ff <= 1'b0;
        end else if (stop_i) begin
            running_ff <= 1'b0;
        end else if (start_i) begin
            running_ff <= 1'b1;
        end else if (expire && !reload_i) begin
            running_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Count value
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_ff <= evtmr_pkg::COUNT_RST;
        end else if (on_i && !stop_i && start_i) begin
            count_ff <= preset_i;
        end else if (on_i && !stop_i && running_ff && step) begin
            if (count_ff == '0) begin
                count_ff <= reload_i ? preset_i : count_ff;
            end else begin
                count_ff <= count_ff - CNT_W'(1);
            end
        end
    end

    assign count_o = count_ff;
    assign running_o = running_ff;

endmodule // evtmr_counter

`default_nettype wire

// File: src/evtmr_top.sv
/*
 * Event triggered countdown timers, two instances, with an Avalon-MM
 * register slave. Transceiver and field events arrive as one-cycle
 * strobes synchronous to clk_i; the contactless clock arrives as a strobe.
 */
// Chosen here: the Avalon-MM slave port.
// Summary of operation
// - immediate start bit starts timer at once
// - rate field picks prescaler tick, halving per code
// - mode clear counts every contactless clock cycle
// - mode set counts on prescaler ticks
// - reload clear: stop and hold zero
// - reload set: load preset and continue
// - timer runs only while enable set
// - halt after first four received bits
// - halt when transmission begins
// - halt when external field appears
// - halt when external field is lost
// - halt when own field turns on
// - halt when own field turns off
// - start on first received bit
// - start when reception ends
// - one 20-bit preset per timer, shared by start and reload
// - readable running flag, cleared at reset
`timescale 1ns/10ps
`default_nettype none

module evtmr_top #(
    parameter int unsigned CNT_W = evtmr_pkg::CNT_W,
    parameter int unsigned NT = evtmr_pkg::NUM_TIMERS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave
    input wire logic [evtmr_pkg::ADDR_W+1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [evtmr_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [evtmr_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Contactless interface clock strobe
    input wire logic contactless_interface_clock_i,
    // Transceiver and field event strobes
    input wire logic rx_first_bit_i,
    input wire logic rx_four_bits_i,
    input wire logic rx_end_i,
    input wire logic tx_begin_i,
    input wire logic tx_end_i,
    input wire logic ext_field_seen_i,
    input wire logic ext_field_lost_i,
    input wire logic own_field_on_i,
    input wire logic own_field_off_i,
    // Timer status
    output logic [NT-1:0] timer_running_o
);

    localparam int unsigned CM = evtmr_pkg::CFG_MSB;
    localparam int unsigned AW = evtmr_pkg::ADDR_W;
    localparam int unsigned DW = evtmr_pkg::DATA_W;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic ack_ff;
    logic req;
    logic wr_en;
    logic [AW-1:0] idx;
    logic [DW-1:0] be_mask;
    logic [DW-1:0] rdata_ff;
    logic [DW-1:0] nxt_rdata;
    logic [CM:0] cfg_ff [NT];
    logic [CNT_W-1:0] preset_ff [NT];
    logic [NT-1:0] imm_start_ff;
    logic [NT-1:0] cfg_hit;
    logic [NT-1:0] preset_hit;
    logic [NT-1:0] status_hit;
    logic [NT-1:0] presc_tick;
    logic [NT-1:0] go;
    logic [NT-1:0] halt;
    logic [CNT_W-1:0] count [NT];
    logic [NT-1:0] running;

    // ------------------------------------------------------------------
    // Bus handshake: one wait state per access
    // ------------------------------------------------------------------
    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_ff;
    assign wr_en = avs_write_i & ack_ff;
    assign idx = avs_address_i[AW+1:evtmr_pkg::IDX_LSB];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    always_comb begin
        be_mask = '0;
        for (int b = 0; b < 4; b++) begin
            be_mask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign cfg_hit[0] = (idx == evtmr_pkg::IDX_T0_CONFIG);
    assign cfg_hit[1] = (idx == evtmr_pkg::IDX_T1_CONFIG);
    assign preset_hit[0] = (idx == evtmr_pkg::IDX_T0_PRESET);
    assign preset_hit[1] = (idx == evtmr_pkg::IDX_T1_PRESET);
    assign status_hit[0] = (idx == evtmr_pkg::IDX_T0_STATUS);
    assign status_hit[1] = (idx == evtmr_pkg::IDX_T1_STATUS);

    // ------------------------------------------------------------------
    // Config and preset registers
    // ------------------------------------------------------------------
    for (genvar t = 0; t < NT; t++) begin : g_regs
        logic [DW-1:0] cfg_word;
        logic [DW-1:0] preset_word;

        assign cfg_word = (avs_writedata_i & be_mask)
                        | (DW'(cfg_ff[t]) & ~be_mask);
        assign preset_word = (avs_writedata_i & be_mask)
                           | (DW'(preset_ff[t]) & ~be_mask);

        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                cfg_ff[t] <= evtmr_pkg::CFG_RST;
            end else if (wr_en && cfg_hit[t]) begin
                // Start-now bit is stored as a pulse only
                cfg_ff[t] <= cfg_word[CM:0]
                           & ~((CM+1)'(1) << evtmr_pkg::CFG_IMM_START);
            end
        end

        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                imm_start_ff[t] <= 1'b0;
            end else begin
                imm_start_ff[t] <= wr_en & cfg_hit[t]
                                 & cfg_word[evtmr_pkg::CFG_IMM_START];
            end
        end

        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                preset_ff[t] <= evtmr_pkg::PRESET_RST;
            end else if (wr_en && preset_hit[t]) begin
                preset_ff[t] <= preset_word[CNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Event selection per timer
    // ------------------------------------------------------------------
    for (genvar t = 0; t < NT; t++) begin : g_events
        logic [CM:0] c;
        assign c = cfg_ff[t];

        assign halt[t] =
            (c[evtmr_pkg::CFG_HALT_RX_BEGIN] & rx_four_bits_i)
            | (c[evtmr_pkg::CFG_HALT_TX_BEGIN] & tx_begin_i)
            | (c[evtmr_pkg::CFG_HALT_EXT_SEEN] & ext_field_seen_i)
            | (c[evtmr_pkg::CFG_HALT_EXT_LOST] & ext_field_lost_i)
            | (c[evtmr_pkg::CFG_HALT_OWN_ON] & own_field_on_i)
            | (c[evtmr_pkg::CFG_HALT_OWN_OFF] & own_field_off_i);

        assign go[t] = imm_start_ff[t]
            | (c[evtmr_pkg::CFG_GO_RX_BEGIN] & rx_first_bit_i)
            | (c[evtmr_pkg::CFG_GO_RX_END] & rx_end_i)
            | (c[evtmr_pkg::CFG_GO_TX_BEGIN] & tx_begin_i)
            | (c[evtmr_pkg::CFG_GO_TX_END] & tx_end_i)
            | (c[evtmr_pkg::CFG_GO_EXT_SEEN] & ext_field_seen_i)
            | (c[evtmr_pkg::CFG_GO_EXT_LOST] & ext_field_lost_i)
            | (c[evtmr_pkg::CFG_GO_OWN_ON] & own_field_on_i)
            | (c[evtmr_pkg::CFG_GO_OWN_OFF] & own_field_off_i);

        evtmr_prescaler u_presc (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .rate_i(c[evtmr_pkg::CFG_RATE_MSB:evtmr_pkg::CFG_RATE_LSB]),
            .contactless_interface_clock_tick_i(contactless_interface_clock_i),
            .tick_o(presc_tick[t])
        );

        evtmr_counter #(
            .CNT_W(CNT_W)
        ) u_cnt (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .on_i(c[evtmr_pkg::CFG_ON]),
            .clk_mode_i(c[evtmr_pkg::CFG_CLK_MODE]),
            .reload_i(c[evtmr_pkg::CFG_RELOAD]),
            .contactless_interface_clock_tick_i(contactless_interface_clock_i),
            .presc_tick_i(presc_tick[t]),
            .start_i(go[t]),
            .stop_i(halt[t]),
            .preset_i(preset_ff[t]),
            .count_o(count[t]),
            .running_o(running[t])
        );
    end

    assign timer_running_o = running;

    // ------------------------------------------------------------------
    // Read data; unmapped reads return zero
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdata = evtmr_pkg::RDATA_RST;
        for (int t = 0; t < NT; t++) begin
            if (cfg_hit[t]) begin
                nxt_rdata = DW'(cfg_ff[t]);
            end
            if (preset_hit[t]) begin
                nxt_rdata = DW'(preset_ff[t]);
            end
            if (status_hit[t]) begin
                nxt_rdata = DW'({running[t], count[t]});
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= evtmr_pkg::RDATA_RST;
        end else if (avs_read_i && !ack_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_readdata_o = rdata_ff;

endmodule // evtmr_top

`default_nettype wire

// File: verif/evtmr_props.sv
/*
 Port checker for the timer block: bus handshake, start, halt, enable.
 Assumes the bench writes whole words (all byte lanes on).
*/
`timescale 1ns/10ps
`default_nettype none

module evtmr_props #(
    parameter int unsigned NT = evtmr_pkg::NUM_TIMERS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register bus
    input wire logic [evtmr_pkg::ADDR_W+1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [evtmr_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [evtmr_pkg::DATA_W-1:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Events
    input wire logic rx_first_bit_i,
    input wire logic rx_four_bits_i,
    input wire logic rx_end_i,
    input wire logic tx_begin_i,
    input wire logic ext_field_seen_i,
    input wire logic ext_field_lost_i,
    input wire logic own_field_on_i,
    input wire logic own_field_off_i,
    // Status
    input wire logic [NT-1:0] timer_running_o
);
    // ------------------------------------------------------------------
    // Config shadow
    // ------------------------------------------------------------------
    logic [7:0] idx;
    logic acc;
    logic [20:0] c0_ff;
    logic [20:0] c1_ff;
    logic [1:0] on_sh;
    logic halt1;
    logic go1;
    assign idx = avs_address_i[9:2];
    assign acc = avs_write_i & ~avs_waitrequest_o;
    assign on_sh = {c1_ff[0], c0_ff[0]};
    assign halt1 = c1_ff[0] & |(c1_ff[20:15] & {rx_four_bits_i, tx_begin_i,
        ext_field_seen_i, ext_field_lost_i, own_field_on_i, own_field_off_i});
    assign go1 = c1_ff[0] & |(c1_ff[14:13] & {rx_first_bit_i, rx_end_i});

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            c0_ff <= evtmr_pkg::CFG_RST;
        end else if (acc && idx == evtmr_pkg::IDX_T0_CONFIG) begin
            c0_ff <= avs_writedata_i[20:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            c1_ff <= evtmr_pkg::CFG_RST;
        end else if (acc && idx == evtmr_pkg::IDX_T1_CONFIG) begin
            c1_ff <= avs_writedata_i[20:0];
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    first_wait_a: assert property ($rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o)
        else $error("new request not held off");
    wait_one_a: assert property ((avs_read_i | avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("more than one wait state");
    idle_free_a: assert property (!(avs_read_i | avs_write_i) |-> !avs_waitrequest_o)
        else $error("wait request while idle");
    unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o
        && !(idx inside {8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0E, 8'h0F})
        |-> avs_readdata_o == 32'h00000000) else $error("unmapped read not zero");
    start_now_a: assert property (
        acc && idx == evtmr_pkg::IDX_T0_CONFIG && avs_writedata_i[6] && avs_writedata_i[0]
        |-> ##[1:3] timer_running_o[0]) else $error("immediate start missing");
    enable_gate_a: assert property (
        (~on_sh & ~$past(on_sh) & ~$past(on_sh, 2) & timer_running_o[1:0]) == 2'b00)
        else $error("timer runs while disabled");
    halt_one_a: assert property (
        halt1 |-> ##[1:2] !timer_running_o[1]) else $error("selected halt ignored");
    go_one_a: assert property (
        go1 && !halt1 |-> ##[1:2] timer_running_o[1]) else $error("selected start ignored");
endmodule // evtmr_props

`default_nettype wire

// File: verif/test_event_triggered_countdown_timer.sv
/*
 Bench for the timer block: bus tasks, event pulses, status checks.
 Assumes the bus answers after one wait state and events are strobes.
*/
`timescale 1ns/10ps
`default_nettype none

module test_event_triggered_countdown_timer;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [9:0] adr = 10'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [31:0] rdat;
    logic wreq;
    logic contactless_interface_clock = 1'b0;
    logic [8:0] ev = 9'h000;
    logic [1:0] run;
    logic [31:0] q;
    int bad_count = 0;
    int comparisons = 0;
    int stop_ev[6] = '{1, 3, 5, 6, 7, 8};

    always #2 clk_i = ~clk_i;

    evtmr_top dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .contactless_interface_clock_i(contactless_interface_clock), .rx_first_bit_i(ev[0]),
        .rx_four_bits_i(ev[1]), .rx_end_i(ev[2]), .tx_begin_i(ev[3]), .tx_end_i(ev[4]),
        .ext_field_seen_i(ev[5]), .ext_field_lost_i(ev[6]), .own_field_on_i(ev[7]),
        .own_field_off_i(ev[8]), .timer_running_o(run));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] b(input int i);
        return 32'h00000001 << i;
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until the edge that samples wait request low
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
        int n;
        n = 0;
        adr <= {i, 2'b00};
        wd <= d;
        rd <= ~w;
        wr <= w;
        @(posedge clk_i);
        while (wreq !== 1'b0) begin
            n++;
            if (n > 20) begin
                bad_count++;
                report_and_stop();
            end
            @(posedge clk_i);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rchk(input string name, input logic [7:0] i, input logic [31:0] exp);
        bus(1'b0, i, 32'h00000000);
        check(name, q, exp);
    endtask

    task automatic pulse(input int k);
        ev <= 9'h001 << k;
        @(posedge clk_i);
        ev <= 9'h000;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic step(input int n);
        repeat (n) begin
            contactless_interface_clock <= 1'b1;
            @(posedge clk_i);
            contactless_interface_clock <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        check("running", {30'h0, run}, 32'h00000000);
        rchk("t0 status", evtmr_pkg::IDX_T0_STATUS, 32'h00000000);
        rchk("t1 config", evtmr_pkg::IDX_T1_CONFIG, 32'h00000000);
        bus(1'b1, 8'h3F, 32'hFFFFFFFF);
        rchk("unmapped", 8'h3F, 32'h00000000);
        bus(1'b1, evtmr_pkg::IDX_T1_PRESET, 32'hFFFFFFFF);
        rchk("t1 preset", evtmr_pkg::IDX_T1_PRESET, 32'h000FFFFF);
        bus(1'b1, evtmr_pkg::IDX_T0_PRESET, 32'h00000003);
        bus(1'b1, evtmr_pkg::IDX_T0_CONFIG, 32'h00000041);
        rchk("start now", evtmr_pkg::IDX_T0_STATUS, b(evtmr_pkg::STAT_RUN) | 32'h3);
        step(3);
        rchk("at zero", evtmr_pkg::IDX_T0_STATUS, b(evtmr_pkg::STAT_RUN));
        step(1);
        rchk("expired", evtmr_pkg::IDX_T0_STATUS, 32'h00000000);
        step(2);
        rchk("held zero", evtmr_pkg::IDX_T0_STATUS, 32'h00000000);
        bus(1'b1, evtmr_pkg::IDX_T0_PRESET, 32'h00000002);
        bus(1'b1, evtmr_pkg::IDX_T0_CONFIG, 32'h00000043);
        step(3);
        rchk("reloaded", evtmr_pkg::IDX_T0_STATUS, b(evtmr_pkg::STAT_RUN) | 32'h2);
        // Ascending rates: divider never starts above a new limit
        bus(1'b1, evtmr_pkg::IDX_T0_PRESET, 32'h00000005);
        for (int r = 0; r < 8; r++) begin
            bus(1'b1, evtmr_pkg::IDX_T0_CONFIG, 32'h00000045 | (32'(r) << 3));
            step(4 << r);
            rchk("divided", evtmr_pkg::IDX_T0_STATUS, b(evtmr_pkg::STAT_RUN) | 32'h3);
        end
        bus(1'b1, evtmr_pkg::IDX_T1_PRESET, 32'h00000064);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, evtmr_pkg::IDX_T1_CONFIG, 32'h00000041 | b(20 - i));
            pulse(0);
            pulse(stop_ev[(i + 1) % 6]);
            check("not halted", run[1], 1'b1);
            pulse(stop_ev[i]);
            check("halted", run[1], 1'b0);
        end
        bus(1'b1, evtmr_pkg::IDX_T1_CONFIG, 32'h001F8041);
        pulse(5);
        check("any halt", run[1], 1'b0);
        bus(1'b1, evtmr_pkg::IDX_T1_CONFIG, b(14) | 32'h1);
        pulse(2);
        check("no start", run[1], 1'b0);
        pulse(0);
        rchk("rx start", evtmr_pkg::IDX_T1_STATUS, b(evtmr_pkg::STAT_RUN) | 32'h64);
        bus(1'b1, evtmr_pkg::IDX_T1_CONFIG, 32'h00000040);
        repeat (3) @(posedge clk_i);
        check("disabled", run[1], 1'b0);
        bus(1'b1, evtmr_pkg::IDX_T1_CONFIG, b(13) | 32'h1);
        pulse(0);
        check("no start", run[1], 1'b0);
        pulse(2);
        check("rx end start", run[1], 1'b1);
        bus(1'b1, evtmr_pkg::IDX_T1_CONFIG, 32'h00000000);
        bus(1'b1, evtmr_pkg::IDX_T1_CONFIG, 32'h00000901);
        pulse(4);
        check("any start", run[1], 1'b1);
        // Mid-run reset clears running flags and presets
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        check("reset run", {30'h0, run}, 32'h00000000);
        rchk("reset preset", evtmr_pkg::IDX_T1_PRESET, 32'h00000000);
        report_and_stop();
    end
endmodule // test_event_triggered_countdown_timer

bind evtmr_top evtmr_props #(.NT(NT)) chk (.*);

`default_nettype wire
